// ===== rtl/dtspm_pin_mux.sv
`timescale 1ns/1ns
module dtspm_pin_mux #(
    parameter bit FULL_VARIANT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    // pads: bit 0 phase-b, bit 1 index, bit 2 home
    input wire logic [dtspm_pkg::NUM_PINS-1:0] pad_in_i,
    output dtspm_pkg::dtspm_pad_t [dtspm_pkg::NUM_PINS-1:0] pad_o,
    // configuration writes
    input wire logic pin_sel_wr_i,
    input wire logic [dtspm_pkg::NUM_PINS-1:0] pin_sel_i,
    input wire logic gpio_en_wr_i,
    input wire logic [dtspm_pkg::NUM_PINS-1:0] gpio_en_i,
    input wire logic gpio_dir_wr_i,
    input wire logic [dtspm_pkg::NUM_PINS-1:0] gpio_dir_i,
    input wire logic gpio_data_wr_i,
    input wire logic [dtspm_pkg::NUM_PINS-1:0] gpio_data_i,
    input wire logic timer_sel_wr_i,
    input wire logic [dtspm_pkg::NUM_PINS-1:0] timer_sel_i,
    input wire logic pullup_wr_i,
    input wire logic [dtspm_pkg::PUR_W-1:0] pullup_i,
    // configuration readback and pad pull-up controls
    output logic [dtspm_pkg::NUM_PINS-1:0] system_pin_select_reg_o,
    output logic [dtspm_pkg::PUR_W-1:0] port_c_pullup_reg_o,
    output logic [dtspm_pkg::NUM_PINS-1:0] pin_configured_o,
    // timer b channels 1..3 at bits 0..2
    input wire logic [dtspm_pkg::NUM_PINS-1:0] timer_b_ch_out_i,
    input wire logic [dtspm_pkg::NUM_PINS-1:0] timer_b_ch_oe_i,
    output logic [dtspm_pkg::NUM_PINS-1:0] timer_b_ch_in_o,
    // spi port 1 core side
    input wire dtspm_pkg::dtspm_spi_t spi_i,
    output logic spi_port1_master_out_o,
    output logic spi_port1_master_in_o,
    output logic spi_port1_slave_select_o,
    // decoder 1 inputs
    output logic decoder1_phase_b_in_o,
    output logic decoder1_index_in_o,
    output logic decoder1_home_in_o,
    // port c pins 1..3 read value
    output logic [dtspm_pkg::NUM_PINS-1:0] port_c_pin_in_o
);

    localparam int NP = dtspm_pkg::NUM_PINS;

    // ----------------------------------------------------------------
    // ownership decode
    // ----------------------------------------------------------------
    function automatic dtspm_pkg::dtspm_func_t pin_owner(
        input logic unconf,
        input logic gpio_en,
        input logic alt,
        input logic tmr
    );
        dtspm_pkg::dtspm_func_t f;
        f = dtspm_pkg::FN_DECODER;
        if (unconf)
            f = dtspm_pkg::FN_NONE;
        else if (gpio_en)
            f = dtspm_pkg::FN_GPIO;
        else if (alt)
            f = dtspm_pkg::FN_SPI;
        else if (tmr)
            f = dtspm_pkg::FN_TIMER;
        return f;
    endfunction : pin_owner

    logic [NP-1:0] system_pin_select_reg_ff;
    logic [NP-1:0] gpio_en_ff;
    logic [NP-1:0] gpio_dir_ff;
    logic [NP-1:0] gpio_data_ff;
    logic [NP-1:0] timer_sel_ff;
    logic [dtspm_pkg::PUR_W-1:0] port_c_pullup_reg_ff;
    logic [NP-1:0] unconf_ff;
    logic [NP-1:0] pin_lvl;
    dtspm_pkg::dtspm_func_t own [NP];
    dtspm_pkg::dtspm_pad_t [NP-1:0] nxt_pad;
    dtspm_pkg::dtspm_pad_t [NP-1:0] pad_ff;
    logic slave_sel;
    logic [NP-1:0] timer_in_ff;
    logic [NP-1:0] gpio_in_ff;
    logic mosi_rx_ff;
    logic miso_rx_ff;
    logic ss_ff;
    logic dec_b_ff;
    logic dec_i_ff;
    logic dec_h_ff;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // pin select: alt bits for phase-b, index, home
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            system_pin_select_reg_ff <= dtspm_pkg::PSEL_RST;
        else if (pin_sel_wr_i)
            system_pin_select_reg_ff <= pin_sel_i;
    end

    // gpio enable, direction and data per pin
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            gpio_en_ff <= dtspm_pkg::GPIO_EN_RST;
            gpio_dir_ff <= dtspm_pkg::GPIO_DIR_RST;
            gpio_data_ff <= dtspm_pkg::GPIO_DATA_RST;
        end
        else
        begin
            if (gpio_en_wr_i)
                gpio_en_ff <= gpio_en_i;
            if (gpio_dir_wr_i)
                gpio_dir_ff <= gpio_dir_i;
            if (gpio_data_wr_i)
                gpio_data_ff <= gpio_data_i;
        end
    end

    // timer b channel select
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            timer_sel_ff <= dtspm_pkg::TSEL_RST;
        else if (timer_sel_wr_i)
            timer_sel_ff <= timer_sel_i;
    end

    // pull-up enables, a cleared bit turns the pull-up off
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            port_c_pullup_reg_ff <= dtspm_pkg::PUR_RST;
        else if (pullup_wr_i)
            port_c_pullup_reg_ff <= pullup_i;
    end

    // reduced variant: no function until a selection is written
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            unconf_ff <= FULL_VARIANT ? {NP{1'b0}} : {NP{1'b1}};
        else if (pin_sel_wr_i || gpio_en_wr_i || timer_sel_wr_i)
            unconf_ff <= {NP{1'b0}};
    end

    // ----------------------------------------------------------------
    // per pin sync, ownership and drive
    // ----------------------------------------------------------------
    assign slave_sel = (own[dtspm_pkg::PIN_HOME] == dtspm_pkg::FN_SPI) &&
                       !pin_lvl[dtspm_pkg::PIN_HOME];

    for (genvar p = 0; p < NP; p++)
    begin : g_pin
        dtspm_pin_sync u_sync (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .async_i(pad_in_i[p]),
            .level_o(pin_lvl[p])
        );

        // one owner per pin
        assign own[p] = pin_owner(unconf_ff[p], gpio_en_ff[p],
                                  system_pin_select_reg_ff[p], timer_sel_ff[p]);

        // drive value for the owning function
        always_comb
        begin
            nxt_pad[p] = '0;
            case (own[p])
                dtspm_pkg::FN_GPIO:
                begin
                    nxt_pad[p].out = gpio_data_ff[p];
                    nxt_pad[p].oe = gpio_dir_ff[p];
                end
                dtspm_pkg::FN_TIMER:
                begin
                    nxt_pad[p].out = timer_b_ch_out_i[p];
                    nxt_pad[p].oe = timer_b_ch_oe_i[p];
                end
                dtspm_pkg::FN_SPI:
                begin
                    if (p == dtspm_pkg::PIN_PHASE_B)
                    begin
                        nxt_pad[p].out = spi_i.mosi_out;
                        nxt_pad[p].oe = spi_i.master;
                    end
                    else if (p == dtspm_pkg::PIN_INDEX)
                    begin
                        nxt_pad[p].out = spi_i.miso_out;
                        nxt_pad[p].oe = !spi_i.master && slave_sel;
                    end
                end
                default:
                begin
                    nxt_pad[p] = '0; // decoder, none: input only
                end
            endcase
        end

        // registered pad drive, same delay for every path
        always_ff @(posedge core_clk_i)
        begin
            if (rst_i)
                pad_ff[p] <= '0;
            else
                pad_ff[p] <= nxt_pad[p];
        end

        // inputs reach only the owning function
        always_ff @(posedge core_clk_i)
        begin
            if (rst_i)
            begin
                timer_in_ff[p] <= dtspm_pkg::DATA_IDLE;
                gpio_in_ff[p] <= dtspm_pkg::DATA_IDLE;
            end
            else
            begin
                timer_in_ff[p] <= (own[p] == dtspm_pkg::FN_TIMER) ? pin_lvl[p] : dtspm_pkg::DATA_IDLE;
                gpio_in_ff[p] <= (own[p] == dtspm_pkg::FN_GPIO) ? pin_lvl[p] : dtspm_pkg::DATA_IDLE;
            end
        end
    end

    // ----------------------------------------------------------------
    // spi and decoder receive paths
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            mosi_rx_ff <= dtspm_pkg::DATA_IDLE;
            miso_rx_ff <= dtspm_pkg::DATA_IDLE;
            ss_ff <= dtspm_pkg::SS_IDLE;
        end
        else
        begin
            mosi_rx_ff <= (own[dtspm_pkg::PIN_PHASE_B] == dtspm_pkg::FN_SPI && !spi_i.master) ?
                          pin_lvl[dtspm_pkg::PIN_PHASE_B] : dtspm_pkg::DATA_IDLE;
            miso_rx_ff <= (own[dtspm_pkg::PIN_INDEX] == dtspm_pkg::FN_SPI && spi_i.master) ?
                          pin_lvl[dtspm_pkg::PIN_INDEX] : dtspm_pkg::DATA_IDLE;
            ss_ff <= (own[dtspm_pkg::PIN_HOME] == dtspm_pkg::FN_SPI) ?
                     pin_lvl[dtspm_pkg::PIN_HOME] : dtspm_pkg::SS_IDLE;
        end
    end

    // decoder 1 inputs
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            dec_b_ff <= dtspm_pkg::DATA_IDLE;
            dec_i_ff <= dtspm_pkg::DATA_IDLE;
            dec_h_ff <= dtspm_pkg::DATA_IDLE;
        end
        else
        begin
            dec_b_ff <= (own[dtspm_pkg::PIN_PHASE_B] == dtspm_pkg::FN_DECODER) ?
                        pin_lvl[dtspm_pkg::PIN_PHASE_B] : dtspm_pkg::DATA_IDLE;
            dec_i_ff <= (own[dtspm_pkg::PIN_INDEX] == dtspm_pkg::FN_DECODER) ?
                        pin_lvl[dtspm_pkg::PIN_INDEX] : dtspm_pkg::DATA_IDLE;
            dec_h_ff <= (own[dtspm_pkg::PIN_HOME] == dtspm_pkg::FN_DECODER) ?
                        pin_lvl[dtspm_pkg::PIN_HOME] : dtspm_pkg::DATA_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pad_o = pad_ff;
    assign system_pin_select_reg_o = system_pin_select_reg_ff;
    assign port_c_pullup_reg_o = port_c_pullup_reg_ff;
    assign pin_configured_o = ~unconf_ff;
    assign timer_b_ch_in_o = timer_in_ff;
    assign port_c_pin_in_o = gpio_in_ff;
    assign spi_port1_master_out_o = mosi_rx_ff;
    assign spi_port1_master_in_o = miso_rx_ff;
    assign spi_port1_slave_select_o = ss_ff;
    assign decoder1_phase_b_in_o = dec_b_ff;
    assign decoder1_index_in_o = dec_i_ff;
    assign decoder1_home_in_o = dec_h_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking chk_cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    chk_gpio_out_drive: assert property (
        (own[dtspm_pkg::PIN_INDEX] == dtspm_pkg::FN_GPIO) |=>
        (pad_o[dtspm_pkg::PIN_INDEX].oe == $past(gpio_dir_ff[dtspm_pkg::PIN_INDEX])) &&
        (pad_o[dtspm_pkg::PIN_INDEX].out == $past(gpio_data_ff[dtspm_pkg::PIN_INDEX])))
        else $error("gpio pin drive does not follow direction and data");

    chk_pullup_write: assert property (
        pullup_wr_i |=> port_c_pullup_reg_o == $past(pullup_i))
        else $error("pull-up register write not applied");

    chk_full_reset_dec: assert property (
        (FULL_VARIANT && $past(rst_i) && !pin_sel_wr_i) |->
        (own[dtspm_pkg::PIN_HOME] == dtspm_pkg::FN_DECODER) && (pad_o == '0))
        else $error("full variant pin not decoder after reset");

    chk_reduced_reset_none: assert property (
        (!FULL_VARIANT && $past(rst_i)) |->
        (pin_configured_o == '0) && (pad_o == '0) && !decoder1_phase_b_in_o)
        else $error("reduced variant pin has a function after reset");

    chk_mosi_master_drive: assert property (
        (own[dtspm_pkg::PIN_PHASE_B] == dtspm_pkg::FN_SPI && spi_i.master) |=>
        pad_o[dtspm_pkg::PIN_PHASE_B].oe && (pad_o[dtspm_pkg::PIN_PHASE_B].out == $past(spi_i.mosi_out)))
        else $error("mosi not driven in master mode");

    chk_miso_slave_drive: assert property (
        (own[dtspm_pkg::PIN_INDEX] == dtspm_pkg::FN_SPI && !spi_i.master && slave_sel) |=>
        pad_o[dtspm_pkg::PIN_INDEX].oe)
        else $error("miso not driven by selected slave");

    chk_miso_hiz_unsel: assert property (
        (own[dtspm_pkg::PIN_INDEX] == dtspm_pkg::FN_SPI && !slave_sel) |=>
        !pad_o[dtspm_pkg::PIN_INDEX].oe)
        else $error("miso driven while not selected");

    chk_ss_input_only: assert property (
        (own[dtspm_pkg::PIN_HOME] == dtspm_pkg::FN_SPI) |=>
        !pad_o[dtspm_pkg::PIN_HOME].oe && (spi_port1_slave_select_o == $past(pin_lvl[dtspm_pkg::PIN_HOME])))
        else $error("slave select pin not an input");

    chk_home_decoder_in: assert property (
        (own[dtspm_pkg::PIN_HOME] == dtspm_pkg::FN_DECODER) |=>
        decoder1_home_in_o == $past(pin_lvl[dtspm_pkg::PIN_HOME]))
        else $error("home pin not routed to decoder");

    chk_unowned_quiet: assert property (
        (own[dtspm_pkg::PIN_PHASE_B] != dtspm_pkg::FN_DECODER) ##1
        (own[dtspm_pkg::PIN_PHASE_B] != dtspm_pkg::FN_DECODER) |->
        !decoder1_phase_b_in_o && ($past(own[dtspm_pkg::PIN_PHASE_B]) == dtspm_pkg::FN_TIMER ||
        !timer_b_ch_in_o[dtspm_pkg::PIN_PHASE_B]))
        else $error("decoder sees pin activity while not owner");

    cov_spi_master: cover property (
        own[dtspm_pkg::PIN_PHASE_B] == dtspm_pkg::FN_SPI && spi_i.master ##1 pad_o[dtspm_pkg::PIN_PHASE_B].oe);
    cov_spi_slave_sel: cover property (
        slave_sel && !spi_i.master ##1 pad_o[dtspm_pkg::PIN_INDEX].oe);
    cov_gpio_output: cover property (
        own[dtspm_pkg::PIN_HOME] == dtspm_pkg::FN_GPIO && gpio_dir_ff[dtspm_pkg::PIN_HOME]);
    cov_timer_drive: cover property (
        own[dtspm_pkg::PIN_INDEX] == dtspm_pkg::FN_TIMER && timer_b_ch_oe_i[dtspm_pkg::PIN_INDEX]);

endmodule : dtspm_pin_mux

// ===== rtl/dtspm_pin_sync.sv
`timescale 1ns/1ns
module dtspm_pin_sync (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o
);

    logic [dtspm_pkg::SYNC_STAGES-1:0] stage_ff;
    logic level_ff;

    // ----------------------------------------------------------------
    // three stage shift, first stage only feeds the second
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            stage_ff <= {dtspm_pkg::SYNC_STAGES{dtspm_pkg::SYNC_RST}};
        end
        else
        begin
            stage_ff <= {stage_ff[dtspm_pkg::SYNC_STAGES-2:0], async_i};
        end
    end

    // accept a change once the last two stages agree
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            level_ff <= dtspm_pkg::SYNC_RST;
        end
        else if (stage_ff[1] == stage_ff[2])
        begin
            level_ff <= stage_ff[2];
        end
    end

    assign level_o = level_ff;

endmodule : dtspm_pin_sync

// ===== rtl/dtspm_pkg.sv
//
// Contract
// - each gpio pin individually input or output
// - cleared pull-up bit disables that pull-up
// - full variant resets pins to decoder inputs
// - reduced variant resets pins to no function
// - phase-b alt bit routes spi mosi
// - select_a bit routes spi miso
// - select_b bit routes spi slave select
// - master drives mosi; slave receives it
// - slave drives miso; master receives it
// - unselected slave leaves miso undriven
// - master mode: slave select is input
// - pins also carry decoder and timer b
//
package dtspm_pkg;

    // ----------------------------------------------------------------
    // pin layout
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 3;
    localparam int PIN_PHASE_B = 0;
    localparam int PIN_INDEX = 1;
    localparam int PIN_HOME = 2;

    // ----------------------------------------------------------------
    // pull-up register layout and reset values
    // ----------------------------------------------------------------
    localparam int PUR_W = 4;
    localparam int PUR_PHASE_A_BIT = 0;
    localparam int PUR_PIN_BASE = 1;
    localparam logic [PUR_W-1:0] PUR_RST = 4'hf;
    localparam logic [NUM_PINS-1:0] PSEL_RST = 3'h0;
    localparam logic [NUM_PINS-1:0] GPIO_EN_RST = 3'h0;
    localparam logic [NUM_PINS-1:0] GPIO_DIR_RST = 3'h0;
    localparam logic [NUM_PINS-1:0] GPIO_DATA_RST = 3'h0;
    localparam logic [NUM_PINS-1:0] TSEL_RST = 3'h0;

    // ----------------------------------------------------------------
    // synchroniser and idle levels
    // ----------------------------------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam logic SYNC_RST = 1'h1;
    localparam logic SS_IDLE = 1'h1;
    localparam logic DATA_IDLE = 1'h0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FN_NONE,
        FN_DECODER,
        FN_TIMER,
        FN_SPI,
        FN_GPIO
    } dtspm_func_t;

    typedef struct packed {
        logic out;
        logic oe;
    } dtspm_pad_t;

    typedef struct packed {
        logic master;
        logic mosi_out;
        logic miso_out;
    } dtspm_spi_t;

endpackage : dtspm_pkg

// ===== tb/dtspm_pin_mux_tb.sv
`timescale 1ns/1ns
module dtspm_pin_mux_tb;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    localparam int W_PSEL = 0;
    localparam int W_GEN = 1;
    localparam int W_GDIR = 2;
    localparam int W_GDAT = 3;
    localparam int W_TSEL = 4;
    localparam int W_PUR = 5;
    logic core_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [5:0] wr = 6'h0;
    logic [3:0] dat [6] = '{default: 4'h0};
    logic [3:0] pur_set [4] = '{4'hf, 4'ha, 4'h5, 4'h0};
    logic [2:0] ext_en = 3'h7;
    logic [2:0] ext_val = 3'h0;
    logic [2:0] tmr_out = 3'h0;
    logic [2:0] tmr_oe = 3'h0;
    dtspm_pkg::dtspm_spi_t spi = '0;
    dtspm_pkg::dtspm_pad_t [2:0] pad_w;
    dtspm_pkg::dtspm_pad_t [2:0] red_pad;
    logic [2:0] pad_lvl, oe_v, out_v, red_oe, sel_rb, cfg_v, tmr_in, gpio_in, dec_v, red_cfg, red_dec;
    logic [3:0] pur_rb;
    logic mosi_rx, miso_rx, ss_rx, clash;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    // clock
    always #50 core_clk_i = ~core_clk_i;

    assign oe_v = {pad_w[2].oe, pad_w[1].oe, pad_w[0].oe};
    assign out_v = {pad_w[2].out, pad_w[1].out, pad_w[0].out};
    assign red_oe = {red_pad[2].oe, red_pad[1].oe, red_pad[0].oe};

    // full variant under test
    dtspm_pin_mux #(.FULL_VARIANT(1'b1)) i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pad_in_i(pad_lvl), .pad_o(pad_w),
        .pin_sel_wr_i(wr[0]), .pin_sel_i(dat[0][2:0]), .gpio_en_wr_i(wr[1]), .gpio_en_i(dat[1][2:0]),
        .gpio_dir_wr_i(wr[2]), .gpio_dir_i(dat[2][2:0]), .gpio_data_wr_i(wr[3]), .gpio_data_i(dat[3][2:0]),
        .timer_sel_wr_i(wr[4]), .timer_sel_i(dat[4][2:0]), .pullup_wr_i(wr[5]), .pullup_i(dat[5]),
        .system_pin_select_reg_o(sel_rb), .port_c_pullup_reg_o(pur_rb), .pin_configured_o(cfg_v),
        .timer_b_ch_out_i(tmr_out), .timer_b_ch_oe_i(tmr_oe), .timer_b_ch_in_o(tmr_in), .spi_i(spi),
        .spi_port1_master_out_o(mosi_rx), .spi_port1_master_in_o(miso_rx), .spi_port1_slave_select_o(ss_rx),
        .decoder1_phase_b_in_o(dec_v[0]), .decoder1_index_in_o(dec_v[1]), .decoder1_home_in_o(dec_v[2]),
        .port_c_pin_in_o(gpio_in)
    );

    // reduced variant sharing the same stimulus
    dtspm_pin_mux #(.FULL_VARIANT(1'b0)) i_red (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pad_in_i(pad_lvl), .pad_o(red_pad),
        .pin_sel_wr_i(wr[0]), .pin_sel_i(dat[0][2:0]), .gpio_en_wr_i(wr[1]), .gpio_en_i(dat[1][2:0]),
        .gpio_dir_wr_i(wr[2]), .gpio_dir_i(dat[2][2:0]), .gpio_data_wr_i(wr[3]), .gpio_data_i(dat[3][2:0]),
        .timer_sel_wr_i(wr[4]), .timer_sel_i(dat[4][2:0]), .pullup_wr_i(wr[5]), .pullup_i(dat[5]),
        .system_pin_select_reg_o(), .port_c_pullup_reg_o(), .pin_configured_o(red_cfg),
        .timer_b_ch_out_i(tmr_out), .timer_b_ch_oe_i(tmr_oe), .timer_b_ch_in_o(), .spi_i(spi),
        .spi_port1_master_out_o(), .spi_port1_master_in_o(), .spi_port1_slave_select_o(),
        .decoder1_phase_b_in_o(red_dec[0]), .decoder1_index_in_o(red_dec[1]), .decoder1_home_in_o(red_dec[2]),
        .port_c_pin_in_o()
    );

    dtspm_pin_peer i_peer (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pad_i(pad_w), .pullup_i(pur_rb),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pad_lvl), .clash_o(clash)
    );

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #10;
    endtask : tick

    // one-cycle write pulse; readback is valid on return
    task automatic cfg(input int sel, input logic [3:0] v);
        @(posedge core_clk_i);
        wr[sel] <= 1'h1;
        dat[sel] <= v;
        @(posedge core_clk_i);
        wr[sel] <= 1'h0;
        #10;
    endtask : cfg

    // far side drives pins, then waits out the synchroniser
    task automatic drive(input logic [2:0] en, input logic [2:0] val);
        @(posedge core_clk_i);
        ext_en <= en;
        ext_val <= val;
        tick(7);
    endtask : drive

    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // hang guard
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            errors++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'h0;
        tick(1);
        chk("pullup reset", 4'hf, pur_rb);
        chk("select reset", 4'h0, {1'h0, sel_rb});
        chk("pad drive reset", 4'h0, {1'h0, oe_v});
        chk("full configured", 4'h7, {1'h0, cfg_v});
        drive(3'h7, 3'h5);
        chk("decoder inputs", 4'h5, {1'h0, dec_v});
        chk("gpio unselected", 4'h0, {1'h0, gpio_in});
        chk("reduced unconfigured", 4'h0, {1'h0, red_cfg});
        chk("reduced decoder", 4'h0, {1'h0, red_dec});
        chk("reduced pads", 4'h0, {1'h0, red_oe});
        cfg(W_PSEL, 4'h0);
        tick(3);
        chk("reduced configured", 4'h7, {1'h0, red_cfg});
        chk("reduced decoder on", 4'h5, {1'h0, red_dec});
        // pull-ups hold released gpio inputs high, cleared bits let them float
        cfg(W_GEN, 4'h7);
        foreach (pur_set[k])
        begin
            drive(3'h7, 3'h0);
            cfg(W_PUR, pur_set[k]);
            chk("pullup readback", pur_set[k], pur_rb);
            drive(3'h0, 3'h0);
            chk("pulled pins", {1'h0, pur_set[k][3:1]}, {1'h0, gpio_in});
        end
        // gpio direction per pin
        cfg(W_GDIR, 4'h5);
        cfg(W_GDAT, 4'h1);
        drive(3'h2, 3'h2);
        chk("gpio drive enable", 4'h5, {1'h0, oe_v});
        chk("gpio drive value", 4'h1, {1'h0, out_v & oe_v});
        chk("gpio pin view", 4'h3, {1'h0, gpio_in});
        chk("decoder unselected", 4'h0, {1'h0, dec_v});
        cfg(W_GDAT, 4'h4);
        tick(7);
        chk("gpio new value", 4'h4, {1'h0, out_v & oe_v});
        chk("gpio new view", 4'h6, {1'h0, gpio_in});
        // spi master: mosi out, miso and select in
        cfg(W_GEN, 4'h0);
        @(posedge core_clk_i);
        spi <= 3'h6;
        drive(3'h6, 3'h6);
        cfg(W_PSEL, 4'h7);
        chk("select readback", 4'h7, {1'h0, sel_rb});
        tick(1);
        chk("master pads", 4'h1, {1'h0, oe_v});
        chk("mosi value", 4'h1, {1'h0, out_v & oe_v});
        tick(6);
        chk("master miso in", 4'h1, {3'h0, miso_rx});
        chk("select level high", 4'h1, {3'h0, ss_rx});
        drive(3'h6, 3'h2);
        chk("select stays input", 4'h1, {1'h0, oe_v});
        chk("select level low", 4'h0, {3'h0, ss_rx});
        chk("miso follows pin", 4'h1, {3'h0, miso_rx});
        // spi slave: miso released until selected
        @(posedge core_clk_i);
        spi <= 3'h1;
        drive(3'h5, 3'h5);
        chk("unselected miso", 4'h0, {1'h0, oe_v});
        chk("slave mosi in", 4'h1, {3'h0, mosi_rx});
        drive(3'h5, 3'h1);
        chk("selected miso", 4'h2, {1'h0, oe_v});
        chk("miso value", 4'h2, {1'h0, out_v & oe_v});
        // timer b channels, then spi takes pin 0 back
        cfg(W_PSEL, 4'h0);
        cfg(W_TSEL, 4'h7);
        @(posedge core_clk_i);
        tmr_oe <= 3'h2;
        tmr_out <= 3'h2;
        drive(3'h5, 3'h1);
        chk("timer drive", 4'h2, {1'h0, oe_v});
        chk("timer value", 4'h2, {1'h0, out_v & oe_v});
        chk("timer pin view", 4'h1, {1'h0, tmr_in & 3'h5});
        chk("decoder off", 4'h0, {1'h0, dec_v});
        cfg(W_PSEL, 4'h1);
        tick(3);
        chk("spi over timer", 4'h1, {3'h0, mosi_rx});
        chk("timer keeps ch2", 4'h2, {1'h0, oe_v});
        chk("no drive clash", 4'h0, {3'h0, clash});
        // second reset in mid-run
        @(posedge core_clk_i);
        rst_i <= 1'h1;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'h0;
        tick(1);
        chk("select after reset", 4'h0, {1'h0, sel_rb});
        chk("pullup after reset", 4'hf, pur_rb);
        chk("pads after reset", 4'h0, {1'h0, oe_v});
        conclude();
    end
endmodule : dtspm_pin_mux_tb

// ===== tb/dtspm_pin_peer.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// far side of the pins: encoder, spi peer, timer load, pull-ups
// ----------------------------------------------------------------
module dtspm_pin_peer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire dtspm_pkg::dtspm_pad_t [2:0] pad_i,
    input wire logic [3:0] pullup_i,
    input wire logic [2:0] ext_en_i,
    input wire logic [2:0] ext_val_i,
    output logic [2:0] level_o,
    output logic clash_o
);
    logic [2:0] last_ff = 3'h0;
    logic clash_ff = 1'h0;

    // wire level: device first, then far side, pull-up, else floating
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (pad_i[i].oe)
                level_o[i] = pad_i[i].out;
            else if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else if (pullup_i[i + 1])
                level_o[i] = 1'h1;
            else
                level_o[i] = ~last_ff[i]; // floating wire never holds
        end
    end

    // remember levels, flag two drivers on one wire
    always_ff @(posedge core_clk_i)
    begin
        last_ff <= level_o;
        if (rst_i)
            clash_ff <= 1'h0;
        else
            clash_ff <= clash_ff | (|({pad_i[2].oe, pad_i[1].oe, pad_i[0].oe} & ext_en_i));
    end
    assign clash_o = clash_ff;
endmodule : dtspm_pin_peer
